// ### rtl/tcc_channel.sv
/*
 * one 16-bit timer channel with its block glue: clock selection,
 * clock control, triggers and capture into registers a and b.
 * assumes a plain register port on core_clk, read data one cycle after
 * the read strobe; pins and peer line a signals are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module tcc_channel (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire logic [tcc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [tcc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [tcc_pkg::DATA_W-1:0] reg_rdata,
    // external clock pins and peer channel line a
    input wire logic [2:0] ext_clock_pin,
    input wire logic [1:0] peer_line_a,
    // io line a
    input wire logic io_line_a_in,
    output logic io_line_a_out,
    output logic io_line_a_oe,
    // io line b
    input wire logic io_line_b_in,
    output logic io_line_b_out,
    output logic io_line_b_oe,
    // sync pulse to the sibling channels
    output logic sync_out
);
    import tcc_pkg::*;

    // ==========================================================
    // input synchronisers
    logic [N_SYNC_IN-1:0] raw_in;
    logic [N_SYNC_IN-1:0] sync1_q;
    logic [N_SYNC_IN-1:0] sync2_q;
    logic [N_SYNC_IN-1:0] sync3_q;

    assign raw_in = {peer_line_a, io_line_b_in, io_line_a_in, ext_clock_pin};

    genvar gi;
    generate
        for (gi = 0; gi < N_SYNC_IN; gi++) begin : g_sync
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    sync3_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= raw_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                end
            end
        end
    endgenerate

    logic [2:0] pin_s;
    logic [1:0] peer_s;
    logic line_a_s, line_a_d, line_b_s, line_b_d;
    assign pin_s = sync2_q[2:0];
    assign line_a_s = sync2_q[3];
    assign line_b_s = sync2_q[4];
    assign peer_s = sync2_q[6:5];
    assign line_a_d = sync3_q[3];
    assign line_b_d = sync3_q[4];

    // ==========================================================
    // registers
    logic [CMR_W-1:0] cmr_q;
    logic [BMR_W-1:0] bmr_q;
    logic [CNT_W-1:0] cv_q, ra_q, rb_q, rc_q;
    logic clk_en_q, clk_run_q, trig_pend_q;
    logic counter_overflow_flag_q, load_overrun_flag_q, ra_unread_q, rb_unread_q, a_next_q;
    logic clk_prev_q;

    logic wave;
    logic wr_ccr, wr_cmr, wr_rc, wr_bcr, wr_bmr, wr_ra, wr_rb;
    logic rd_sr, rd_ra, rd_rb;
    assign wave = cmr_q[CMR_WAVE];
    assign wr_ccr = reg_wr && (reg_addr == OFS_CCR);
    assign wr_cmr = reg_wr && (reg_addr == OFS_CMR);
    assign wr_rc = reg_wr && (reg_addr == OFS_RC);
    assign wr_ra = reg_wr && (reg_addr == OFS_RA) && wave;
    assign wr_rb = reg_wr && (reg_addr == OFS_RB) && wave;
    assign wr_bcr = reg_wr && (reg_addr == OFS_BCR);
    assign wr_bmr = reg_wr && (reg_addr == OFS_BMR);
    assign rd_sr = reg_rd && (reg_addr == OFS_SR);
    assign rd_ra = reg_rd && (reg_addr == OFS_RA);
    assign rd_rb = reg_rd && (reg_addr == OFS_RB);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cmr_q <= CMR_RESET;
            bmr_q <= BMR_RESET;
            rc_q <= CNT_ZERO;
        end else begin
            if (wr_cmr) begin
                cmr_q <= reg_wdata[CMR_W-1:0];
            end
            if (wr_bmr) begin
                bmr_q <= reg_wdata[BMR_W-1:0];
            end
            if (wr_rc) begin
                rc_q <= reg_wdata[CNT_W-1:0];
            end
        end
    end

    // ==========================================================
    // clock selection
    logic [N_INT_CLK-1:0] int_clk;
    logic [2:0] xc;
    logic [2:0] clks;
    logic sel_lvl, clk_lvl, burst_ok, tick;

    tcc_prescaler u_prescaler (
        .core_clk(core_clk),
        .rst(rst),
        .int_clk(int_clk)
    );

    generate
        for (gi = 0; gi < 3; gi++) begin : g_xc
            always_comb begin
                if (bmr_q[2*gi +: 2] == XC_PIN) begin
                    xc[gi] = pin_s[gi];
                end else if (bmr_q[2*gi +: 2] == XC_PEER0) begin
                    xc[gi] = peer_s[0];
                end else if (bmr_q[2*gi +: 2] == XC_PEER1) begin
                    xc[gi] = peer_s[1];
                end else begin
                    xc[gi] = 1'b0;
                end
            end
        end
    endgenerate

    assign clks = cmr_q[CMR_CLKS_LO +: 3];

    always_comb begin
        if (clks < CLKS_XC0) begin
            sel_lvl = int_clk[clks];
        end else begin
            sel_lvl = xc[2'(clks - CLKS_XC0)];
        end
    end

    assign clk_lvl = sel_lvl ^ cmr_q[CMR_CLOCK_INVERT];

    always_comb begin
        if (cmr_q[CMR_BURST_LO +: 2] == BURST_NONE) begin
            burst_ok = 1'b1;
        end else begin
            burst_ok = xc[2'(cmr_q[CMR_BURST_LO +: 2] - 2'h1)];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clk_prev_q <= 1'b0;
        end else begin
            clk_prev_q <= clk_lvl;
        end
    end

    assign tick = clk_lvl && !clk_prev_q && burst_ok;

    // ==========================================================
    // triggers
    logic sw_trig, sync_trig, cmp_evt, cmp_trig, ext_sig, ext_sig_d, ext_trig;
    logic [1:0] tedg;
    logic ext_on;

    assign sw_trig = wr_ccr && reg_wdata[CCR_SOFT_TRIGGER_CMD];
    assign sync_trig = wr_bcr && reg_wdata[BCR_SYNC];
    assign cmp_evt = tick && (cv_q == rc_q);
    assign cmp_trig = cmp_evt && cmr_q[CMR_COMPARE_C_TRIGGER_ENABLE];
    assign tedg = cmr_q[CMR_TEDG_LO +: 2];

    always_comb begin
        if (!wave) begin
            ext_on = 1'b1;
            if (cmr_q[CMR_EXT_TRIGGER_SOURCE_SELECT]) begin
                ext_sig = line_a_s;
                ext_sig_d = line_a_d;
            end else begin
                ext_sig = line_b_s;
                ext_sig_d = line_b_d;
            end
        end else begin
            ext_on = cmr_q[CMR_EXT_EVENT_TRIGGER_ENABLE];
            if (cmr_q[CMR_EEVT_LO +: 2] == EEVT_LINE_B) begin
                ext_sig = line_b_s;
                ext_sig_d = line_b_d;
            end else begin
                ext_sig = xc[2'(cmr_q[CMR_EEVT_LO +: 2] - 2'h1)];
                ext_sig_d = ext_sig;
            end
        end
    end

    // the delayed copy of xc is not kept, so waveform events use line b only
    always_comb begin
        if (tedg == EDGE_RISE) begin
            ext_trig = ext_on && ext_sig && !ext_sig_d;
        end else if (tedg == EDGE_FALL) begin
            ext_trig = ext_on && !ext_sig && ext_sig_d;
        end else if (tedg == EDGE_BOTH) begin
            ext_trig = ext_on && (ext_sig != ext_sig_d);
        end else begin
            ext_trig = 1'b0;
        end
    end

    logic any_trig;
    assign any_trig = sw_trig || sync_trig || cmp_trig || ext_trig;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync_out <= 1'b0;
        end else begin
            sync_out <= sync_trig;
        end
    end

    // ==========================================================
    // capture edge detection
    logic a_rise, a_fall, ld_a_edge, ld_b_edge, load_a, load_b;
    logic [1:0] load_a_edge_select, load_b_edge_select;
    assign a_rise = line_a_s && !line_a_d;
    assign a_fall = !line_a_s && line_a_d;
    assign load_a_edge_select = cmr_q[CMR_LOAD_A_EDGE_SELECT_LO +: 2];
    assign load_b_edge_select = cmr_q[CMR_LOAD_B_EDGE_SELECT_LO +: 2];

    function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
        edge_hit = ((sel == EDGE_RISE) && r) || ((sel == EDGE_FALL) && f)
            || ((sel == EDGE_BOTH) && (r || f));
    endfunction

    assign ld_a_edge = edge_hit(load_a_edge_select, a_rise, a_fall);
    assign ld_b_edge = edge_hit(load_b_edge_select, a_rise, a_fall);
    assign load_a = !wave && ld_a_edge && a_next_q;
    assign load_b = !wave && ld_b_edge && !a_next_q && !load_a;

    // ==========================================================
    // clock control
    logic stop_evt, dis_evt;
    assign stop_evt = wave ? (cmp_evt && cmr_q[CMR_STOP]) : (load_b && cmr_q[CMR_STOP]);
    assign dis_evt = wave ? (cmp_evt && cmr_q[CMR_DIS]) : (load_b && cmr_q[CMR_DIS]);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clk_en_q <= 1'b0;
        end else if ((wr_ccr && reg_wdata[CCR_CLOCK_DISABLE_CMD]) || dis_evt) begin
            clk_en_q <= 1'b0;
        end else if (wr_ccr && reg_wdata[CCR_CLOCK_ENABLE_CMD]) begin
            clk_en_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clk_run_q <= 1'b0;
        end else if (!clk_en_q) begin
            clk_run_q <= clk_run_q;
        end else if (any_trig) begin
            clk_run_q <= 1'b1;
        end else if (stop_evt) begin
            clk_run_q <= 1'b0;
        end
    end

    // ==========================================================
    // counter
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            trig_pend_q <= 1'b0;
        end else if (any_trig) begin
            trig_pend_q <= 1'b1;
        end else if (tick) begin
            trig_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cv_q <= CNT_ZERO;
        end else if (tick && trig_pend_q) begin
            cv_q <= CNT_ZERO;
        end else if (tick && clk_en_q && clk_run_q) begin
            cv_q <= cv_q + CNT_ONE;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            counter_overflow_flag_q <= 1'b0;
        end else if (tick && !trig_pend_q && clk_en_q && clk_run_q && (cv_q == CNT_MAX)) begin
            counter_overflow_flag_q <= 1'b1;
        end else if (rd_sr) begin
            counter_overflow_flag_q <= 1'b0;
        end
    end

    // ==========================================================
    // capture registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            a_next_q <= 1'b1;
        end else if (any_trig || load_b) begin
            a_next_q <= 1'b1;
        end else if (load_a) begin
            a_next_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ra_q <= CNT_ZERO;
        end else if (load_a) begin
            ra_q <= cv_q;
        end else if (wr_ra) begin
            ra_q <= reg_wdata[CNT_W-1:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rb_q <= CNT_ZERO;
        end else if (load_b) begin
            rb_q <= cv_q;
        end else if (wr_rb) begin
            rb_q <= reg_wdata[CNT_W-1:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ra_unread_q <= 1'b0;
            rb_unread_q <= 1'b0;
        end else begin
            if (load_a) begin
                ra_unread_q <= 1'b1;
            end else if (rd_ra) begin
                ra_unread_q <= 1'b0;
            end
            if (load_b) begin
                rb_unread_q <= 1'b1;
            end else if (rd_rb) begin
                rb_unread_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            load_overrun_flag_q <= 1'b0;
        end else if ((load_a && ra_unread_q) || (load_b && rb_unread_q)) begin
            load_overrun_flag_q <= 1'b1;
        end else if (rd_sr) begin
            load_overrun_flag_q <= 1'b0;
        end
    end

    // ==========================================================
    // io lines
    logic b_is_event;
    assign b_is_event = (cmr_q[CMR_EEVT_LO +: 2] == EEVT_LINE_B)
        && (tedg != EDGE_NONE);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            io_line_a_oe <= 1'b0;
            io_line_b_oe <= 1'b0;
        end else begin
            io_line_a_oe <= wave;
            io_line_b_oe <= wave && !b_is_event;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            io_line_a_out <= 1'b0;
            io_line_b_out <= 1'b0;
        end else if (!wave) begin
            io_line_a_out <= 1'b0;
            io_line_b_out <= 1'b0;
        end else if (cmp_evt) begin
            io_line_a_out <= !io_line_a_out;
            io_line_b_out <= io_line_b_out;
        end
    end

    // ==========================================================
    // read data
    logic [DATA_W-1:0] sr_val;
    always_comb begin
        sr_val = RD_ZERO;
        sr_val[SR_COUNTER_OVERFLOW_FLAG] = counter_overflow_flag_q;
        sr_val[SR_LOAD_OVERRUN_FLAG] = load_overrun_flag_q;
        sr_val[SR_CLOCK_ENABLED_FLAG] = clk_en_q;
        sr_val[SR_LINE_A] = line_a_s;
        sr_val[SR_LINE_B] = line_b_s;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= RD_ZERO;
        end else if (!reg_rd) begin
            reg_rdata <= reg_rdata;
        end else if (reg_addr == OFS_CMR) begin
            reg_rdata <= {{(DATA_W-CMR_W){1'b0}}, cmr_q};
        end else if (reg_addr == OFS_BMR) begin
            reg_rdata <= {{(DATA_W-BMR_W){1'b0}}, bmr_q};
        end else if (reg_addr == OFS_CV) begin
            reg_rdata <= {{(DATA_W-CNT_W){1'b0}}, cv_q};
        end else if (reg_addr == OFS_RA) begin
            reg_rdata <= {{(DATA_W-CNT_W){1'b0}}, ra_q};
        end else if (reg_addr == OFS_RB) begin
            reg_rdata <= {{(DATA_W-CNT_W){1'b0}}, rb_q};
        end else if (reg_addr == OFS_RC) begin
            reg_rdata <= {{(DATA_W-CNT_W){1'b0}}, rc_q};
        end else if (reg_addr == OFS_SR) begin
            reg_rdata <= sr_val;
        end else begin
            reg_rdata <= RD_ZERO;
        end
    end
endmodule
`default_nettype wire

// ### include/tcc_pkg.sv
/*
 * package for the timer capture channel: register offsets, field
 * positions, encodings and reset values shared by the design files.
 * assumes a 25 MHz core clock and a byte-addressed plain register port.
 */
package tcc_pkg;
    // ==========================================================
    // register port
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CNT_W = 16;
    localparam logic [ADDR_W-1:0] OFS_CCR = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CMR = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CV = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_RA = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_RB = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_RC = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_SR = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_BCR = 8'hC0;
    localparam logic [ADDR_W-1:0] OFS_BMR = 8'hC4;

    // ==========================================================
    // channel control and block control bits
    localparam int unsigned CCR_CLOCK_ENABLE_CMD = 0;
    localparam int unsigned CCR_CLOCK_DISABLE_CMD = 1;
    localparam int unsigned CCR_SOFT_TRIGGER_CMD = 2;
    localparam int unsigned BCR_SYNC = 0;

    // ==========================================================
    // channel mode fields
    localparam int unsigned CMR_W = 20;
    localparam int unsigned CMR_CLKS_LO = 0;
    localparam int unsigned CMR_CLOCK_INVERT = 3;
    localparam int unsigned CMR_BURST_LO = 4;
    localparam int unsigned CMR_STOP = 6;
    localparam int unsigned CMR_DIS = 7;
    localparam int unsigned CMR_TEDG_LO = 8;
    localparam int unsigned CMR_EXT_TRIGGER_SOURCE_SELECT = 10;
    localparam int unsigned CMR_EEVT_LO = 10;
    localparam int unsigned CMR_EXT_EVENT_TRIGGER_ENABLE = 12;
    localparam int unsigned CMR_COMPARE_C_TRIGGER_ENABLE = 14;
    localparam int unsigned CMR_WAVE = 15;
    localparam int unsigned CMR_LOAD_A_EDGE_SELECT_LO = 16;
    localparam int unsigned CMR_LOAD_B_EDGE_SELECT_LO = 18;
    localparam logic [CMR_W-1:0] CMR_RESET = 20'h00000;

    // ==========================================================
    // block mode fields, two bits per external clock input
    localparam int unsigned BMR_W = 6;
    localparam logic [BMR_W-1:0] BMR_RESET = 6'h00;
    localparam logic [1:0] XC_PIN = 2'h0;
    localparam logic [1:0] XC_NONE = 2'h1;
    localparam logic [1:0] XC_PEER0 = 2'h2;
    localparam logic [1:0] XC_PEER1 = 2'h3;

    // ==========================================================
    // status bits
    localparam int unsigned SR_COUNTER_OVERFLOW_FLAG = 0;
    localparam int unsigned SR_LOAD_OVERRUN_FLAG = 1;
    localparam int unsigned SR_CLOCK_ENABLED_FLAG = 16;
    localparam int unsigned SR_LINE_A = 17;
    localparam int unsigned SR_LINE_B = 18;

    // ==========================================================
    // encodings and constants
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [1:0] BURST_NONE = 2'h0;
    localparam logic [2:0] CLKS_XC0 = 3'h5;
    localparam logic [1:0] EEVT_LINE_B = 2'h0;
    localparam int unsigned N_INT_CLK = 5;
    localparam int unsigned N_SYNC_IN = 7;
    localparam int unsigned PRESCALE_W = 10;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [DATA_W-1:0] RD_ZERO = 32'h00000000;
endpackage

// ### rtl/tcc_prescaler.sv
/*
 * free-running divider giving the five internal timer clocks as levels.
 * assumes the core clock; taps select the division ratio of each level.
 */
`timescale 1ns/1ps
`default_nettype none
module tcc_prescaler #(
    parameter int unsigned TAP0 = 0,
    parameter int unsigned TAP1 = 2,
    parameter int unsigned TAP2 = 4,
    parameter int unsigned TAP3 = 6,
    parameter int unsigned TAP4 = 9
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // internal clock levels
    output logic [tcc_pkg::N_INT_CLK-1:0] int_clk
);
    import tcc_pkg::*;

    // ==========================================================
    // divider chain
    logic [PRESCALE_W-1:0] div_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + {{(PRESCALE_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            int_clk <= '0;
        end else begin
            int_clk <= {div_q[TAP4], div_q[TAP3], div_q[TAP2], div_q[TAP1], div_q[TAP0]};
        end
    end
endmodule
`default_nettype wire

// ### verification/tcc_channel_props.sv
/* checker for the timer channel ports.
   assumes plain register port strobes and one core clock. */
`timescale 1ns/1ps
`default_nettype none
module tcc_channel_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire logic [tcc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [tcc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [tcc_pkg::DATA_W-1:0] reg_rdata,
    // lines and sync
    input wire logic io_line_a_oe,
    input wire logic io_line_b_oe,
    input wire logic sync_out
);
    import tcc_pkg::*;
    // ==========================================================
    // mode tracking
    logic wave_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) wave_q <= 1'b0;
        else if (reg_wr && reg_addr == OFS_CMR) wave_q <= reg_wdata[CMR_WAVE];
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // sequences
    sequence s_sync;
        reg_wr && reg_addr == OFS_BCR && reg_wdata[BCR_SYNC];
    endsequence
    sequence s_en;
        reg_wr && reg_addr == OFS_CCR && reg_wdata[CCR_CLOCK_ENABLE_CMD] && !reg_wdata[CCR_CLOCK_DISABLE_CMD];
    endsequence
    sequence s_dis;
        reg_wr && reg_addr == OFS_CCR && reg_wdata[CCR_CLOCK_DISABLE_CMD];
    endsequence
    sequence s_rd_sr;
        reg_rd && reg_addr == OFS_SR;
    endsequence
    // ==========================================================
    // assertions
    a_sync_after_write: assert property (s_sync |=> sync_out)
        else $error("sync pulse missing");
    a_sync_one_cycle: assert property (sync_out |=> !sync_out)
        else $error("sync pulse too long");
    a_sync_has_cause: assert property (sync_out |-> $past(reg_wr && reg_addr == OFS_BCR))
        else $error("sync pulse without write");
    a_enable_shows: assert property (s_en ##2 s_rd_sr |=> reg_rdata[SR_CLOCK_ENABLED_FLAG])
        else $error("clock enabled flag low");
    a_disable_shows: assert property (s_dis ##2 s_rd_sr |=> !reg_rdata[SR_CLOCK_ENABLED_FLAG])
        else $error("clock enabled flag high");
    a_capture_lines_in: assert property (!wave_q && $past(!wave_q) |-> !io_line_a_oe && !io_line_b_oe)
        else $error("line driven in capture mode");
    a_wave_line_a: assert property (wave_q && $past(wave_q) |-> io_line_a_oe)
        else $error("line a not driven");
    a_count_width: assert property (reg_rd && reg_addr == OFS_CV |=> reg_rdata[31:16] == 16'h0000)
        else $error("count wider than 16 bits");
endmodule
bind tcc_channel tcc_channel_props u_props (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .io_line_a_oe(io_line_a_oe), .io_line_b_oe(io_line_b_oe), .sync_out(sync_out));
`default_nettype wire

// ### verification/tcc_pin_model.sv
/* far side of the channel: external clock and measured line a.
   assumes requests from the bench just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // requests
    input wire logic clk_run,
    input wire logic pulse_req,
    // pins
    output logic xclk,
    output logic line_a
);
    logic [2:0] div_q;
    logic [2:0] pul_q;
    // clock 4 high 4 low, parked low between bursts
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) div_q <= 3'h0;
        else if (clk_run || div_q != 3'h0) div_q <= div_q + 3'h1;
    end
    // pulse held 6 cycles
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) pul_q <= 3'h0;
        else if (pulse_req) pul_q <= 3'h6;
        else if (pul_q != 3'h0) pul_q <= pul_q - 3'h1;
    end
    assign xclk = div_q[2];
    assign line_a = pul_q != 3'h0;
endmodule
`default_nettype wire

// ### verification/tb.sv
/* self-checking bench for the timer channel.
   assumes the pin model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tcc_pkg::*;
    // ==========================================================
    // signals and instances
    logic core_clk, rst, reg_wr, reg_rd, clk_run, pulse_req, xclk, line_a;
    logic a_out, a_oe, b_out, b_oe, sync_out;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, d, e;
    int n_errors = 0;
    int checks = 0;
    wire a_wire = a_oe ? a_out : line_a;
    wire b_wire = b_oe ? b_out : 1'b0;
    tcc_channel u_tcc_channel (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_clock_pin({2'b00, xclk}), .peer_line_a({1'b0, xclk}), .io_line_a_in(a_wire),
        .io_line_a_out(a_out), .io_line_a_oe(a_oe), .io_line_b_in(b_wire),
        .io_line_b_out(b_out), .io_line_b_oe(b_oe), .sync_out(sync_out));
    tcc_pin_model u_tcc_pin_model (.core_clk(core_clk), .rst(rst), .clk_run(clk_run),
        .pulse_req(pulse_req), .xclk(xclk), .line_a(line_a));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // ==========================================================
    // tasks
    task automatic check(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] x);
        checks++;
        if (s !== x) begin
            n_errors++;
            $display("BAD t=%0t seen %h want %h", $time, s, x);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        d = reg_rdata;
    endtask
    task automatic burst;
        clk_run <= 1'b1;
        repeat (80) @(posedge core_clk);
        clk_run <= 1'b0;
        repeat (12) @(posedge core_clk);
        rd(OFS_CV);
    endtask
    task automatic pulse;
        pulse_req <= 1'b1;
        @(posedge core_clk);
        pulse_req <= 1'b0;
        repeat (20) @(posedge core_clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #800000;
        n_errors++;
        wrap_up();
    end
    // ==========================================================
    // tests
    initial begin
        {rst, reg_wr, reg_rd, clk_run, pulse_req} = 5'h10;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        for (int i = 0; i < 9; i++) begin
            rd(8'(i * 4 + 4));
            if (i != 0 && i != 3) check(d, 32'h0);
        end
        $display("reset values done");
        wr(OFS_CCR, 32'h1);
        rd(OFS_SR);
        check(32'(d[SR_CLOCK_ENABLED_FLAG]), 32'h1);
        wr(OFS_CCR, 32'h3);
        rd(OFS_SR);
        check(32'(d[SR_CLOCK_ENABLED_FLAG]), 32'h0);
        wr(OFS_CCR, 32'h1);
        wr(OFS_CCR, 32'h4);
        repeat (20) @(posedge core_clk);
        rd(OFS_CV);
        e = d;
        repeat (18) @(posedge core_clk);
        rd(OFS_CV);
        check(d - e, 32'hA);
        wr(OFS_CCR, 32'h4);
        rd(OFS_CV);
        check(32'(d < 32'h5), 32'h1);
        repeat (30) @(posedge core_clk);
        wr(OFS_BCR, 32'h1);
        rd(OFS_CV);
        check(32'(d < 32'h5), 32'h1);
        wr(OFS_RC, 32'h20);
        wr(OFS_CMR, 32'h4000);
        repeat (6) begin
            repeat (37) @(posedge core_clk);
            rd(OFS_CV);
            check(32'(d <= 32'h20), 32'h1);
        end
        $display("count and trigger done");
        wr(OFS_CMR, 32'h5);
        wr(OFS_CCR, 32'h5);
        burst();
        check(d, 32'h9);
        wr(OFS_BMR, 32'h1);
        burst();
        check(d, 32'h9);
        wr(OFS_BMR, 32'h2);
        burst();
        check(d, 32'h13);
        wr(OFS_CMR, 32'hD);
        rd(OFS_CV);
        e = d;
        burst();
        check(d - e, 32'hA);
        wr(OFS_CMR, 32'h10);
        rd(OFS_CV);
        e = d;
        repeat (18) @(posedge core_clk);
        rd(OFS_CV);
        check(d, e);
        $display("clock select done");
        wr(OFS_CMR, 32'h90000);
        wr(OFS_CCR, 32'h5);
        pulse();
        rd(OFS_RA);
        e = d;
        rd(OFS_RB);
        check(d - e, 32'h3);
        pulse();
        rd(OFS_SR);
        check(32'(d[SR_LOAD_OVERRUN_FLAG]), 32'h0);
        pulse();
        rd(OFS_SR);
        check(32'(d[SR_LOAD_OVERRUN_FLAG]), 32'h1);
        wr(OFS_CMR, 32'h10000);
        wr(OFS_CCR, 32'h4);
        pulse();
        rd(OFS_RA);
        e = d;
        pulse();
        rd(OFS_RA);
        check(d, e);
        wr(OFS_CMR, 32'h500);
        repeat (60) @(posedge core_clk);
        pulse();
        rd(OFS_CV);
        check(32'(d < 32'h10), 32'h1);
        $display("capture done");
        wr(OFS_RC, 32'h10);
        wr(OFS_CMR, 32'h84C0);
        wr(OFS_CCR, 32'h5);
        repeat (100) @(posedge core_clk);
        rd(OFS_SR);
        check(32'(d[SR_CLOCK_ENABLED_FLAG]), 32'h0);
        wr(OFS_CCR, 32'h4);
        repeat (4) @(posedge core_clk);
        rd(OFS_CV);
        e = d;
        repeat (18) @(posedge core_clk);
        rd(OFS_CV);
        check(d, e);
        check(32'({a_oe, b_oe}), 32'h3);
        $display("waveform done");
        wrap_up();
    end
endmodule
`default_nettype wire
